//--- sfe_defs.svh
// Constants and operation summary for the serial flash front end
// Operation
// - Single mode captures input on rising clock
// - Single mode drives output on falling clock
// - Dual/quad lines bidirectional, same edges
// - Quad needs quad enable; pins become lines
// - Low write-protect blocks status register writes
// - Quad enable set ignores write-protect function
// - Pause floats output, ignores input and clock
// - Pause starts at pin edge or clock fall
// - Pause ends at pin edge or clock fall
// - Pause only when quad enable clear
// - Pause keeps partial instruction and data
// - Small package line 3 is pause or reset
// - Dedicated reset input ignores quad enable
// - Clock modes 0 and 3 both accepted
// - Commands 3Bh and BBh use two lines
// - Quad reads use four lines
// - 38h enters four-line mode, FFh exits
// - Four-line mode instruction takes two clocks
// - Reset, and 99h right after 66h, return to single mode
// - Four-line entry needs quad enable set
// - Deselected floats all lines; select edge needed
`ifndef SFE_DEFS_SVH
`define SFE_DEFS_SVH
`define SFE_CMD_DUAL_OUT 8'h3B
`define SFE_CMD_DUAL_IO 8'hBB
`define SFE_CMD_QUAD_OUT 8'h6B
`define SFE_CMD_QUAD_IO 8'hEB
`define SFE_CMD_QUAD_WORD 8'hE7
`define SFE_CMD_QUAD_OCT 8'hE3
`define SFE_CMD_ENTER_4L 8'h38
`define SFE_CMD_EXIT_4L 8'hFF
`define SFE_CMD_RST_EN 8'h66
`define SFE_CMD_RST 8'h99
`define SFE_CMD_WR_STATUS 8'h01
`define SFE_ADDR_BYTES 3'h3
`define SFE_IDLE_SEL_N 1'h1
`define SFE_IDLE_SCLK 1'h0
`define SFE_IDLE_LINES 4'hF
`define SFE_IDLE_RST_PIN 1'h1
`endif

//--- sfe_front_end.sv
// Serial flash host-interface front end, sampled from the system clock
`timescale 1ns/10ps
`include "sfe_defs.svh"
module sfe_front_end #(
   parameter bit SMALL_PACKAGE = 1'b1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Serial link pins
   input wire logic sel_n_i,
   input wire logic sclk_i,
   input wire logic [3:0] data_line_i,
   output logic [3:0] data_line_o,
   output logic [3:0] data_line_oe_o,
   input wire logic reset_pin_n_i,
   // Configuration
   input wire logic quad_enable_bit_i,
   input wire logic line3_is_reset_i,
   // Core side
   input wire logic [7:0] rd_data_i,
   output logic [7:0] cmd_o,
   output logic cmd_valid_o,
   output logic [23:0] addr_o,
   output logic [7:0] wr_data_o,
   output logic wr_valid_o,
   output logic rd_next_o,
   output logic four_line_command_mode_o,
   output logic status_write_blocked_o,
   output logic paused_o
);
   // Two-flop synchronisers on every pin; a third flop on select and clock finds their edges
   logic rst_pin_s1, rst_pin_s2;
   logic sel_s1, sel_s2, sel_s3;
   logic sclk_s1, sclk_s2, sclk_s3;
   logic [3:0] din_s1, din_s2;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         // Idle pin levels, so that no false edge or pause follows reset
         rst_pin_s1 <= `SFE_IDLE_RST_PIN;
         rst_pin_s2 <= `SFE_IDLE_RST_PIN;
         sel_s1 <= `SFE_IDLE_SEL_N;
         sel_s2 <= `SFE_IDLE_SEL_N;
         sel_s3 <= `SFE_IDLE_SEL_N;
         sclk_s1 <= `SFE_IDLE_SCLK;
         sclk_s2 <= `SFE_IDLE_SCLK;
         sclk_s3 <= `SFE_IDLE_SCLK;
         din_s1 <= `SFE_IDLE_LINES;
         din_s2 <= `SFE_IDLE_LINES;
      end else begin
         rst_pin_s1 <= reset_pin_n_i;
         rst_pin_s2 <= rst_pin_s1;
         sel_s1 <= sel_n_i;
         sel_s2 <= sel_s1;
         sel_s3 <= sel_s2;
         sclk_s1 <= sclk_i;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         din_s1 <= data_line_i;
         din_s2 <= din_s1;
      end
   end
   // Settled pin levels and detected edges
   wire sel_n = sel_s2;
   wire sclk = sclk_s2;
   wire [3:0] din = din_s2;
   wire rise = sclk & ~sclk_s3;
   wire fall = ~sclk & sclk_s3;
   wire sel_fall = ~sel_n & sel_s3;

   // Pin function decode: line 3 is pause or reset only while quad enable is clear
   wire line3_fn = ~quad_enable_bit_i;
   // Dedicated reset pin on the large package, line 3 as reset on the small one
   wire reset_dedicated = ~rst_pin_s2 & ~SMALL_PACKAGE;
   wire reset_line3 = SMALL_PACKAGE & line3_fn & line3_is_reset_i & ~din[3];
   wire hw_reset = reset_dedicated | reset_line3;
   // Pause request and write protect level
   wire hold_in = line3_fn & ~line3_is_reset_i & ~din[3];
   wire wp_active = ~quad_enable_bit_i & ~din[2];

   // Protocol engine state and its next values
   sfe_pkg::sfe_state_e st, next_st;
   sfe_pkg::sfe_width_e wid, next_wid;
   logic [7:0] sh, next_sh;
   logic [3:0] cnt, next_cnt;
   logic [2:0] acnt, next_acnt;
   logic [7:0] cmd, next_cmd;
   logic [23:0] addr, next_addr;
   logic four_line_command_mode, next_qpi;
   logic armed, next_armed;
   logic rst_en, next_rst_en;
   logic held, next_held;
   logic [7:0] tx, next_tx;
   sfe_pkg::sfe_lines_s lines, next_lines;
   // Next values of the registered core-side outputs
   logic next_cmd_v, next_wr_v, next_rd_next;
   logic [7:0] next_wr;

   // Width of the data phase for a given command
   function automatic sfe_pkg::sfe_width_e cmd_width(input logic [7:0] c, input logic qe);
      if (c == `SFE_CMD_DUAL_OUT || c == `SFE_CMD_DUAL_IO) cmd_width = sfe_pkg::SFE_W2;
      else if (qe && (c == `SFE_CMD_QUAD_OUT || c == `SFE_CMD_QUAD_IO || c == `SFE_CMD_QUAD_WORD
         || c == `SFE_CMD_QUAD_OCT)) cmd_width = sfe_pkg::SFE_W4;
      else cmd_width = sfe_pkg::SFE_W1;
   endfunction

   // Shift in a beat MSB first
   function automatic logic [7:0] shift_in(input logic [7:0] v, input sfe_pkg::sfe_width_e w,
      input logic [3:0] d);
      case (w)
         sfe_pkg::SFE_W2: shift_in = {v[5:0], d[1:0]};
         sfe_pkg::SFE_W4: shift_in = {v[3:0], d};
         default: shift_in = {v[6:0], d[0]};
      endcase
   endfunction

   // Bits per beat
   function automatic logic [3:0] beat_bits(input sfe_pkg::sfe_width_e w);
      case (w)
         sfe_pkg::SFE_W2: beat_bits = 4'h2;
         sfe_pkg::SFE_W4: beat_bits = 4'h4;
         default: beat_bits = 4'h1;
      endcase
   endfunction

   wire [7:0] sh_new = shift_in(sh, wid, din);
   wire [3:0] cnt_new = cnt + beat_bits(wid);
   wire rd_cmd = (cmd_width(cmd, quad_enable_bit_i) != sfe_pkg::SFE_W1) | (cmd == 8'h03) | (cmd == 8'h0B);

   // Next state of the protocol engine
   always_comb begin
      next_st = st;
      next_wid = wid;
      next_sh = sh;
      next_cnt = cnt;
      next_acnt = acnt;
      next_cmd = cmd;
      next_addr = addr;
      next_qpi = four_line_command_mode;
      next_armed = armed;
      next_rst_en = rst_en;
      next_held = held;
      next_tx = tx;
      next_lines = lines;
      next_cmd_v = 1'b0;
      next_wr_v = 1'b0;
      next_wr = wr_data_o;
      next_rd_next = 1'b0;
      // Pause enter/exit only with clock low or on clock fall
      if (~sel_n && (~sclk || fall)) next_held = hold_in;
      // A pin that serves as a data line cannot keep a pause going
      if (quad_enable_bit_i) next_held = 1'b0;
      if (sel_n) next_held = 1'b0;
      // A select fall starts a new instruction
      if (sel_fall) begin
         next_armed = 1'b1;
         next_st = sfe_pkg::SFE_CMD;
         next_wid = four_line_command_mode ? sfe_pkg::SFE_W4 : sfe_pkg::SFE_W1;
         next_cnt = 4'h0;
         next_sh = 8'h00;
      end
      if (sel_n) begin
         next_lines = '0;
         next_st = sfe_pkg::SFE_IDLE;
      end else if (held || hold_in && ~sclk) begin
         next_lines.oe = 4'h0;
      end else if (armed && rise && st != sfe_pkg::SFE_IDLE && !(st == sfe_pkg::SFE_DATA && rd_cmd)) begin
         next_sh = sh_new;
         next_cnt = cnt_new;
         if (cnt_new == 4'h8) begin
            next_cnt = 4'h0;
            case (st)
               sfe_pkg::SFE_CMD: begin
                  next_cmd = sh_new;
                  next_cmd_v = 1'b1;
                  next_rst_en = (sh_new == `SFE_CMD_RST_EN);
                  if (sh_new == `SFE_CMD_ENTER_4L && quad_enable_bit_i) next_qpi = 1'b1;
                  if (sh_new == `SFE_CMD_EXIT_4L) next_qpi = 1'b0;
                  if (sh_new == `SFE_CMD_RST && rst_en) next_qpi = 1'b0;
                  next_acnt = 3'h0;
                  next_st = sfe_pkg::SFE_ADDR;
                  // Address width: output-only reads keep one line, plain commands too
                  if (four_line_command_mode) begin
                     next_wid = sfe_pkg::SFE_W4;
                  end else if (sh_new == `SFE_CMD_DUAL_OUT || sh_new == `SFE_CMD_QUAD_OUT) begin
                     next_wid = sfe_pkg::SFE_W1;
                  end else begin
                     next_wid = cmd_width(sh_new, quad_enable_bit_i);
                  end
               end
               sfe_pkg::SFE_ADDR: begin
                  next_addr = {addr[15:0], sh_new};
                  next_acnt = acnt + 3'h1;
                  // The last address byte opens the data phase and fetches the first read byte
                  if (next_acnt == `SFE_ADDR_BYTES) begin
                     next_st = sfe_pkg::SFE_DATA;
                     if (!four_line_command_mode) next_wid = cmd_width(cmd, quad_enable_bit_i);
                     next_rd_next = rd_cmd;
                     next_tx = rd_data_i;
                  end
               end
               default: begin
                  // Write byte; status writes are held back while protected
                  next_wr = sh_new;
                  next_wr_v = (cmd != `SFE_CMD_WR_STATUS) || !wp_active;
               end
            endcase
         end
      end else if (armed && fall && st == sfe_pkg::SFE_DATA && rd_cmd) begin
         // Drive read data on the falling edge
         case (wid)
            sfe_pkg::SFE_W2: begin
               next_lines.out = {2'h0, tx[7:6]};
               next_lines.oe = 4'h3;
               next_tx = {tx[5:0], 2'h0};
            end
            sfe_pkg::SFE_W4: begin
               next_lines.out = tx[7:4];
               next_lines.oe = 4'hF;
               next_tx = {tx[3:0], 4'h0};
            end
            default: begin
               next_lines.out = {2'h0, tx[7], 1'b0};
               next_lines.oe = 4'h2;
               next_tx = {tx[6:0], 1'b0};
            end
         endcase
         next_cnt = cnt_new;
         if (cnt_new == 4'h8) begin
            next_cnt = 4'h0;
            next_tx = rd_data_i;
            next_rd_next = 1'b1;
         end
      end
   end

   // Registers of the protocol engine, reset pin second only to the asynchronous reset
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= sfe_pkg::SFE_IDLE;
         wid <= sfe_pkg::SFE_W1;
         sh <= 8'h00;
         cnt <= 4'h0;
         acnt <= 3'h0;
         cmd <= 8'h00;
         addr <= 24'h000000;
         four_line_command_mode <= 1'b0;
         armed <= 1'b0;
         rst_en <= 1'b0;
         held <= 1'b0;
         tx <= 8'h00;
         lines <= '0;
         cmd_valid_o <= 1'b0;
         wr_valid_o <= 1'b0;
         wr_data_o <= 8'h00;
         rd_next_o <= 1'b0;
         status_write_blocked_o <= 1'b0;
      end else if (hw_reset) begin
         st <= sfe_pkg::SFE_IDLE;
         four_line_command_mode <= 1'b0;
         armed <= 1'b0;
         rst_en <= 1'b0;
         wid <= sfe_pkg::SFE_W1;
         cnt <= 4'h0;
         lines <= '0;
         held <= 1'b0;
         cmd_valid_o <= 1'b0;
         wr_valid_o <= 1'b0;
         rd_next_o <= 1'b0;
      end else begin
         st <= next_st;
         wid <= next_wid;
         sh <= next_sh;
         cnt <= next_cnt;
         acnt <= next_acnt;
         cmd <= next_cmd;
         addr <= next_addr;
         four_line_command_mode <= next_qpi;
         armed <= next_armed;
         rst_en <= next_rst_en;
         held <= next_held;
         tx <= next_tx;
         lines <= next_lines;
         cmd_valid_o <= next_cmd_v;
         wr_valid_o <= next_wr_v;
         wr_data_o <= next_wr;
         rd_next_o <= next_rd_next;
         status_write_blocked_o <= wp_active;
      end
   end

   // Registered pin drive
   assign data_line_o = lines.out;
   assign data_line_oe_o = lines.oe;
   // Registered core-side and status outputs
   assign cmd_o = cmd;
   assign addr_o = addr;
   assign four_line_command_mode_o = four_line_command_mode;
   assign paused_o = held;
endmodule // sfe_front_end

//--- sfe_front_end_bench.sv
// Self-checking bench for the serial flash front end
`timescale 1ns/10ps
module sfe_front_end_bench;
   logic clk_i, arst_n_i, qe, sel_n, sclk, four_line, blocked, paused;
   logic [3:0] pins, host_line, dout, doe;
   logic [7:0] rd_data, cmd, rx;
   logic [23:0] addr;
   logic rst_pin_n, l3_rst, cmd_v, wr_v, rd_nx;
   logic [7:0] wr_data, last_wr;
   int fail_count, samples_checked, cycles, n_cmd, n_wr, n_rd;
   // Wire level: the device wins where it drives
   assign pins = (dout & doe) | (host_line & ~doe);
   sfe_host_model host (.clk_i(clk_i), .pin_i(pins), .sel_n_o(sel_n), .sclk_o(sclk), .line_o(host_line));
   sfe_front_end uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .sel_n_i(sel_n), .sclk_i(sclk), .data_line_i(pins),
      .data_line_o(dout), .data_line_oe_o(doe), .reset_pin_n_i(rst_pin_n), .quad_enable_bit_i(qe),
      .line3_is_reset_i(l3_rst), .rd_data_i(rd_data), .cmd_o(cmd), .cmd_valid_o(cmd_v), .addr_o(addr),
      .wr_data_o(wr_data), .wr_valid_o(wr_v), .rd_next_o(rd_nx), .four_line_command_mode_o(four_line),
      .status_write_blocked_o(blocked), .paused_o(paused));
   // System clock
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // Hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end
   // Counters of the one-cycle core-side strobes
   always @(posedge clk_i) begin
      n_cmd <= n_cmd + int'(cmd_v);
      n_wr <= n_wr + int'(wr_v);
      n_rd <= n_rd + int'(rd_nx);
      if (wr_v) last_wr <= wr_data;
   end
   task automatic report_and_stop();
      $display("checked %0d failed %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Select, instruction, three address bytes
   task automatic send(input logic [7:0] c, input int w, input logic [23:0] a, input logic cp);
      host.start(cp);
      host.xfer(c, w, rx);
      for (int i = 16; i >= 0; i -= 8) host.xfer(a[i+:8], w, rx);
   endtask
   // Single-width read, then deselect
   task automatic t_read();
      send(8'h03, 1, 24'hA1B2C3, 1'b0);
      host.xfer(8'h00, 1, rx);
      check(rx, 8'h5A);
      check(doe, 4'h2);
      host.stop(1'b0);
      check(cmd, 8'h03);
      check(addr, 24'hA1B2C3);
      check(doe, 4'h0);
      check(24'(n_cmd), 24'h1);
      check(24'(n_rd), 24'h2);
   endtask
   // Pause mid-address with the clock high; stray clocks while paused are ignored
   task automatic t_pause();
      host.start(1'b0);
      host.xfer(8'h0B, 1, rx);
      host.xfer(8'h12, 1, rx);
      host.set_ctl(1'b1, 1'b0);
      check(paused, 1'b0);
      host.beat(4'hF, 1);
      host.beat(4'h0, 1);
      check(paused, 1'b1);
      check(doe, 4'h0);
      host.set_ctl(1'b1, 1'b1);
      check(paused, 1'b1);
      host.xfer(8'h34, 1, rx);
      host.xfer(8'h56, 1, rx);
      host.stop(1'b0);
      check(paused, 1'b0);
      check(addr, 24'h123456);
   endtask
   // Status write with write protect low
   task automatic t_status(input logic q, input logic exp);
      int w0;
      w0 = n_wr;
      qe <= q;
      host.set_ctl(1'b0, 1'b1);
      send(8'h01, 1, 24'h000000, 1'b0);
      host.xfer(8'h02, 1, rx);
      host.stop(1'b0);
      check(blocked, exp);
      check(24'(n_wr - w0), {23'h0, ~exp});
      if (!exp) check(last_wr, 8'h02);
      host.set_ctl(1'b1, 1'b1);
   endtask
   // Four-line mode entry refused, entered in clock mode 3, left by a two-clock code
   task automatic t_four();
      int c0;
      c0 = n_cmd;
      qe <= 1'b0;
      send(8'h38, 1, 24'h0, 1'b1);
      host.stop(1'b1);
      check(four_line, 1'b0);
      qe <= 1'b1;
      send(8'h38, 1, 24'h0, 1'b1);
      host.stop(1'b1);
      check(four_line, 1'b1);
      send(8'hFF, 4, 24'h0, 1'b1);
      host.stop(1'b1);
      check(four_line, 1'b0);
      check(cmd, 8'hFF);
      check(24'(n_cmd - c0), 24'h3);
   endtask
   // Line 3 as reset: a low level drops the open transfer until select falls again
   task automatic t_line3_reset();
      int c0;
      host.set_ctl(1'b1, 1'b1);
      c0 = n_cmd;
      qe <= 1'b0;
      l3_rst <= 1'b1;
      host.start(1'b0);
      host.set_ctl(1'b1, 1'b0);
      host.set_ctl(1'b1, 1'b1);
      host.xfer(8'h03, 1, rx);
      check(doe, 4'h0);
      host.stop(1'b0);
      check(24'(n_cmd - c0), 24'h0);
      send(8'h0B, 1, 24'h00ABCD, 1'b0);
      host.stop(1'b0);
      check(cmd, 8'h0B);
      check(addr, 24'h00ABCD);
      l3_rst <= 1'b0;
   endtask
   // Main sequence
   initial begin
      arst_n_i = 1'b0;
      qe = 1'b0;
      rd_data = 8'h5A;
      rst_pin_n = 1'b1;
      l3_rst = 1'b0;
      fail_count = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      host.set_ctl(1'b1, 1'b1);
      t_read();
      t_pause();
      t_status(1'b0, 1'b1);
      t_status(1'b1, 1'b0);
      t_four();
      t_line3_reset();
      report_and_stop();
   end
endmodule // sfe_front_end_bench

//--- sfe_front_end_properties.sv
// Port-level concurrent checks for the serial flash front end
`timescale 1ns/10ps
module sfe_front_end_properties (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Observed ports
   input wire logic sel_n_i,
   input wire logic quad_enable_bit_i,
   input wire logic [7:0] cmd_o,
   input wire logic [3:0] data_line_oe_o,
   input wire logic wr_valid_o,
   input wire logic four_line_command_mode_o,
   input wire logic status_write_blocked_o,
   input wire logic paused_o
);
   // One clock domain for every check
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   AST_PAUSE_FLOAT: assert property (paused_o |-> data_line_oe_o == 4'h0)
      else $error("lines driven while paused");
   AST_PAUSE_SEL: assert property ($rose(paused_o) |-> !sel_n_i)
      else $error("pause while deselected");
   AST_PAUSE_QE: assert property (paused_o |-> !quad_enable_bit_i)
      else $error("pause with quad enable set");
   AST_DESEL_FLOAT: assert property (sel_n_i [*5] |-> data_line_oe_o == 4'h0)
      else $error("lines driven while deselected");
   AST_SINGLE_LINE1: assert property (cmd_o == 8'h03 |-> data_line_oe_o inside {4'h0, 4'h2})
      else $error("single read on wrong line");
   AST_QPI_QE: assert property ($rose(four_line_command_mode_o) |-> quad_enable_bit_i)
      else $error("four-line mode without quad enable");
   AST_QPI_ENTER: assert property ($rose(four_line_command_mode_o) |-> cmd_o == 8'h38)
      else $error("four-line mode entered by other code");
   AST_QPI_EXIT: assert property ($fell(four_line_command_mode_o) |-> cmd_o inside {8'hFF, 8'h99})
      else $error("four-line mode left by other code");
   AST_WP_IGNORED: assert property ($rose(status_write_blocked_o) |-> !quad_enable_bit_i)
      else $error("write protect honoured with quad enable");
   AST_WR_BLOCKED: assert property (wr_valid_o && cmd_o == 8'h01 |-> !status_write_blocked_o)
      else $error("status write passed while blocked");
   // Main scenarios reached
   cover property ($rose(paused_o));
   cover property ($rose(four_line_command_mode_o));
   cover property ($rose(status_write_blocked_o));
endmodule // sfe_front_end_properties
bind sfe_front_end sfe_front_end_properties chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .sel_n_i(sel_n_i),
   .quad_enable_bit_i(quad_enable_bit_i), .cmd_o(cmd_o), .data_line_oe_o(data_line_oe_o), .wr_valid_o(wr_valid_o),
   .four_line_command_mode_o(four_line_command_mode_o), .status_write_blocked_o(status_write_blocked_o),
   .paused_o(paused_o));

//--- sfe_host_model.sv
// Host-side serial bus master model for the flash front end
`timescale 1ns/10ps
module sfe_host_model (
   // Clock and wire levels
   input wire logic clk_i,
   input wire logic [3:0] pin_i,
   // Driven pins
   output logic sel_n_o,
   output logic sclk_o,
   output logic [3:0] line_o
);
   // Idle pins at time zero
   initial begin
      sel_n_o = 1'b1;
      sclk_o = 1'b0;
      line_o = 4'hF;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Select with the clock already at its idle level
   task automatic start(input logic cpol);
      sclk_o <= cpol;
      wait_clk(4);
      sel_n_o <= 1'b0;
      wait_clk(4);
   endtask
   // Data changes with the clock low, the device takes it on the rise
   task automatic beat(input logic [3:0] v, input int w);
      sclk_o <= 1'b0;
      if (w == 4) line_o <= v;
      else line_o[1:0] <= {~line_o[1], v[0]};
      wait_clk(4);
      sclk_o <= 1'b1;
      wait_clk(4);
   endtask
   // Byte MSB first; read bit taken from line 1 just before the next fall
   task automatic xfer(input logic [7:0] tx, input int w, output logic [7:0] rx);
      for (int i = 8 - w; i >= 0; i -= w) begin
         beat(4'(tx >> i), w);
         rx = {rx[6:0], pin_i[1]};
      end
   endtask
   // Clock back to idle, deselect, lines 0 and 1 show the inverse of their last level
   task automatic stop(input logic cpol);
      sclk_o <= cpol;
      wait_clk(4);
      sel_n_o <= 1'b1;
      line_o[1:0] <= ~line_o[1:0];
      wait_clk(8);
   endtask
   // Write-protect and pause levels; select stays as it is
   task automatic set_ctl(input logic wp_n, input logic hold_n);
      line_o[3:2] <= {hold_n, wp_n};
      wait_clk(6);
   endtask
endmodule // sfe_host_model

//--- sfe_pkg.sv
// Types for the serial flash front end
package sfe_pkg;
   typedef enum logic [1:0] {SFE_W1 = 2'h0, SFE_W2 = 2'h1, SFE_W4 = 2'h3} sfe_width_e;
   typedef enum logic [1:0] {SFE_CMD = 2'h0, SFE_ADDR = 2'h1, SFE_DATA = 2'h3, SFE_IDLE = 2'h2} sfe_state_e;
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } sfe_lines_s;
endpackage
